// File: rtl/tci_pkg.sv
package tci_pkg;
  // ****************************************************
  // target address and timing
  // ****************************************************
  localparam logic [6:0] TCI_TARGET_ADDR = 7'h25;
  localparam int TCI_CLK_HZ = 25000000;
  localparam int TCI_SCL_MAX_KHZ = 400;
  localparam int TCI_SPIKE_NS = 50;
  localparam int TCI_CLK_NS = 1000000000 / TCI_CLK_HZ;
  // spike filter length in cycles, rounded up, at least one
  localparam int TCI_SPIKE_CYC = ((TCI_SPIKE_NS + TCI_CLK_NS - 1) / TCI_CLK_NS) < 1 ? 1 :
    ((TCI_SPIKE_NS + TCI_CLK_NS - 1) / TCI_CLK_NS);
  localparam logic [3:0] TCI_FLT_MAX = 4'(TCI_SPIKE_CYC);
  localparam logic [7:0] TCI_PTR_RST = 8'h00;

  // register port towards the register map
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tci_reg_req_t;
endpackage

// File: rtl/tci_i2c_target.sv
`timescale 1ns/1ns
// Operation
// - The block is an I2C target only: it answers its own address and never starts a transfer.
// - It handles bus clock rates from static up to 400 kHz, and the master keeps below that rate.
// - It answers the 7-bit address 0100101 in the top seven bits of the first byte, bit 0 choosing read or write.
// - A read without a preceding index returns data from the current register pointer onward.
// - Spikes on clock and data up to 50 ns are filtered out and never seen as edges, START or STOP.
module tci_i2c_target
  import tci_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output tci_reg_req_t REG_REQ,
  input wire logic [7:0] REG_RDATA
);
  typedef enum {ST_IDLE, ST_ADDR, ST_AACK, ST_WBYTE, ST_WACK, ST_RBYTE, ST_RACK} tci_state_t;

  // ****************************************************
  // synchronisers and spike filters
  // ****************************************************
  logic [1:0] scl_sync_ff, sda_sync_ff;
  logic [3:0] scl_cnt_ff, sda_cnt_ff;
  logic scl_ff, sda_ff, scl_d_ff, sda_d_ff;

  // two flops per pin before any logic
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
    end
    else
    begin
      scl_sync_ff <= {scl_sync_ff[0], SCL_IN};
      sda_sync_ff <= {sda_sync_ff[0], SDA_IN};
    end
  end

  // level accepted only after it stays longer than a spike
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      scl_cnt_ff <= 4'h0;
      sda_cnt_ff <= 4'h0;
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end
    else
    begin
      if (scl_sync_ff[1] == scl_ff)
        scl_cnt_ff <= 4'h0;
      else if (scl_cnt_ff == TCI_FLT_MAX)
      begin
        scl_ff <= scl_sync_ff[1];
        scl_cnt_ff <= 4'h0;
      end
      else
        scl_cnt_ff <= scl_cnt_ff + 4'h1;
      if (sda_sync_ff[1] == sda_ff)
        sda_cnt_ff <= 4'h0;
      else if (sda_cnt_ff == TCI_FLT_MAX)
      begin
        sda_ff <= sda_sync_ff[1];
        sda_cnt_ff <= 4'h0;
      end
      else
        sda_cnt_ff <= sda_cnt_ff + 4'h1;
    end
  end

  // delayed filtered levels for edge detection
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      scl_d_ff <= scl_ff;
      sda_d_ff <= sda_ff;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_ff && !scl_d_ff;
  assign scl_fall = !scl_ff && scl_d_ff;
  assign start_det = scl_ff && scl_d_ff && sda_d_ff && !sda_ff;
  assign stop_det = scl_ff && scl_d_ff && !sda_d_ff && sda_ff;

  // ****************************************************
  // protocol engine
  // ****************************************************
  tci_state_t state_ff;
  logic [7:0] shift_ff, ptr_ff;
  logic [2:0] bit_ff;
  logic idx_done_ff, drive_ff, rd_req_ff, wr_req_ff, byte_full_ff;
  logic [7:0] wdata_ff;

  // byte engine, filtered clock edges and START/STOP only
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      state_ff <= ST_IDLE;
      shift_ff <= 8'h00;
      bit_ff <= 3'h0;
      ptr_ff <= TCI_PTR_RST;
      idx_done_ff <= 1'b0;
      drive_ff <= 1'b0;
      rd_req_ff <= 1'b0;
      wr_req_ff <= 1'b0;
      wdata_ff <= 8'h00;
      byte_full_ff <= 1'b0;
    end
    else
    begin
      rd_req_ff <= 1'b0;
      wr_req_ff <= 1'b0;
      if (stop_det)
      begin
        state_ff <= ST_IDLE;
        drive_ff <= 1'b0;
      end
      else if (start_det)
      begin
        state_ff <= ST_ADDR;
        bit_ff <= 3'h0;
        drive_ff <= 1'b0;
        idx_done_ff <= 1'b0;
        byte_full_ff <= 1'b0;
      end
      else
      begin
        case (state_ff)
          ST_IDLE:
            drive_ff <= 1'b0;
          ST_ADDR, ST_WBYTE:
          begin
            if (scl_rise)
            begin
              shift_ff <= {shift_ff[6:0], sda_ff};
              bit_ff <= bit_ff + 3'h1;
              byte_full_ff <= (bit_ff == 3'h7); // no byte on the fall right after start
            end
            else if (scl_fall && byte_full_ff)
            begin
              if (state_ff == ST_ADDR)
              begin
                if (shift_ff[7:1] == TCI_TARGET_ADDR)
                begin
                  state_ff <= ST_AACK;
                  drive_ff <= 1'b1;
                  rd_req_ff <= shift_ff[0];
                end
                else
                  state_ff <= ST_IDLE;
              end
              else
              begin
                state_ff <= ST_WACK;
                drive_ff <= 1'b1;
                if (!idx_done_ff)
                begin
                  ptr_ff <= shift_ff;
                  idx_done_ff <= 1'b1;
                end
                else
                begin
                  wdata_ff <= shift_ff;
                  wr_req_ff <= 1'b1;
                end
              end
            end
          end
          ST_AACK:
            if (scl_fall)
            begin
              if (shift_ff[0])
              begin
                state_ff <= ST_RBYTE;
                shift_ff <= REG_RDATA;
                drive_ff <= !REG_RDATA[7];
                bit_ff <= 3'h1;
              end
              else
              begin
                state_ff <= ST_WBYTE;
                drive_ff <= 1'b0;
              end
            end
          ST_WACK:
            if (scl_fall)
            begin
              state_ff <= ST_WBYTE;
              drive_ff <= 1'b0;
            end
          ST_RBYTE:
            if (scl_fall)
            begin
              if (bit_ff == 3'h0)
              begin
                state_ff <= ST_RACK;
                drive_ff <= 1'b0;
                ptr_ff <= ptr_ff + 8'h01;
              end
              else
              begin
                drive_ff <= !shift_ff[3'h7 - bit_ff];
                bit_ff <= bit_ff + 3'h1;
              end
            end
          ST_RACK:
            if (scl_rise)
            begin
              if (sda_ff)
                state_ff <= ST_IDLE;
              else
                rd_req_ff <= 1'b1;
            end
            else if (scl_fall)
            begin
              state_ff <= ST_RBYTE;
              shift_ff <= REG_RDATA;
              drive_ff <= !REG_RDATA[7];
              bit_ff <= 3'h1;
            end
          default:
            state_ff <= ST_IDLE;
        endcase
      end
      if (wr_req_ff)
        ptr_ff <= ptr_ff + 8'h01;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign SDA_OUT = 1'b0;
  assign SDA_OE = drive_ff;
  assign REG_REQ.wr = wr_req_ff;
  assign REG_REQ.rd = rd_req_ff;
  assign REG_REQ.addr = ptr_ff;
  assign REG_REQ.wdata = wdata_ff;

  // ****************************************************
  // assertions
  // ****************************************************
  property p_idle_quiet;
    @(posedge CLOCK) disable iff (!RST_N) (state_ff == ST_IDLE) |-> !SDA_OE;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("sda driven while idle");

  property p_stop_release;
    @(posedge CLOCK) disable iff (!RST_N) stop_det |=> !SDA_OE && state_ff == ST_IDLE;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("sda still driven after stop");

  property p_addr_match;
    @(posedge CLOCK) disable iff (!RST_N)
      (state_ff == ST_ADDR && scl_fall && byte_full_ff && !start_det && !stop_det &&
       shift_ff[7:1] != TCI_TARGET_ADDR) |=> state_ff == ST_IDLE;
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("foreign address answered");

  property p_ack_drive;
    @(posedge CLOCK) disable iff (!RST_N) (state_ff == ST_AACK || state_ff == ST_WACK) |-> SDA_OE;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");

  property p_spike;
    @(posedge CLOCK) disable iff (!RST_N) $changed(scl_ff) |-> $past(scl_sync_ff[1], 2) == scl_ff;
  endproperty
  a_spike: assert property (p_spike) else $error("short spike passed filter");

  property p_index_load;
    @(posedge CLOCK) disable iff (!RST_N) $rose(idx_done_ff) |-> ptr_ff == $past(shift_ff);
  endproperty
  a_index_load: assert property (p_index_load) else $error("index not loaded");
  property p_read_ptr;
    @(posedge CLOCK) disable iff (!RST_N) state_ff == ST_AACK && scl_fall && shift_ff[0]
      |=> shift_ff == $past(REG_RDATA) && REG_REQ.addr == $past(ptr_ff);
  endproperty
  a_read_ptr: assert property (p_read_ptr) else $error("read not from pointer");

  property p_low_only;
    @(posedge CLOCK) disable iff (!RST_N) $changed(SDA_OE) |-> !$past(scl_ff) && !SDA_OUT;
  endproperty
  a_low_only: assert property (p_low_only) else $error("sda changed while clock high");
endmodule

// File: tb/tci_bus_master.sv
`timescale 1ns/1ns
// ****************
// bus master model
// ****************
module tci_bus_master
(
  input wire logic clock,
  input wire logic sda,
  output logic scl_o = 1'b1,
  output logic sda_o = 1'b1
);
  // wait whole clock cycles
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one bit, 64 cycles: 40 low, 24 high; g adds one-cycle spikes
  task automatic bit_slot(input logic b, input logic g, output logic s);
    tick(20);
    sda_o <= b;
    tick(10);
    scl_o <= g;
    tick(1);
    scl_o <= 1'b0;
    tick(9);
    scl_o <= 1'b1;
    tick(12);
    #1 s = sda;
    sda_o <= b | g;
    tick(1);
    sda_o <= b;
    tick(11);
    scl_o <= 1'b0;
  endtask
  // start from idle
  task automatic start();
    sda_o <= 1'b0;
    tick(20);
    scl_o <= 1'b0;
  endtask
  // stop, then bus free
  task automatic stop();
    tick(20);
    sda_o <= 1'b0;
    tick(20);
    scl_o <= 1'b1;
    tick(20);
    sda_o <= 1'b1;
    tick(40);
  endtask
  // send a byte, msb first, and take the ack
  task automatic put_byte(input logic [7:0] b, input logic g, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_slot(b[i], g && i == 7, s);
    bit_slot(1'b1, 1'b0, s);
    ack = ~s;
  endtask
  // take a byte, then refuse more
  task automatic get_byte(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_slot(1'b1, 1'b0, s);
      b = {b[6:0], s};
    end
    bit_slot(1'b1, 1'b0, s);
  endtask
endmodule

// File: tb/tci_i2c_target_bench.sv
`timescale 1ns/1ns
// **********
// bench top
// **********
module tci_i2c_target_bench;
  import tci_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic sda_oe, sda_out, scl, m_sda, ack, sda;
  tci_reg_req_t req;
  logic [7:0] regs [256];
  logic [7:0] idx, d1, d2, b;
  logic [15:0] exp_q [$];
  int n_fail = 0;
  int num_checks = 0;
  int n_rd = 0;
  integer seed = 32'h666e;
  // clock and open-drain line with pull-up
  always #20 clock = ~clock;
  assign sda = m_sda & (~sda_oe | sda_out);
  tci_bus_master m (.clock(clock), .sda(sda), .scl_o(scl), .sda_o(m_sda));
  tci_i2c_target dut (.CLOCK(clock), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .REG_REQ(req), .REG_RDATA(regs[req.addr]));
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // verdict
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // register map stand-in, write and read watcher
  always @(posedge clock)
  begin
    if (req.rd === 1'b1)
      n_rd++;
    if (req.wr === 1'b1)
    begin
      chk({req.addr, req.wdata}, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
      regs[req.addr] <= req.wdata;
    end
  end
  // watchdog
  initial
  begin
    #2000000;
    n_fail++;
    end_sim();
  end
  // main sequence
  initial
  begin
    for (int i = 0; i < 256; i++)
      regs[i] = 8'($random(seed));
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1 chk({req.addr, 7'h00, sda_oe}, {TCI_PTR_RST, 8'h00});
    repeat (4) @(posedge clock);
    for (int r = 0; r < 4; r++)
    begin
      idx = 8'($random(seed));
      d1 = 8'($random(seed)) & 8'h7f;
      d2 = 8'($random(seed));
      exp_q.push_back({idx, d1});
      exp_q.push_back({idx + 8'h01, d2});
      m.start();
      m.put_byte({TCI_TARGET_ADDR, 1'b0}, 1'b0, ack);
      chk({15'h0, ack}, 16'h1);
      m.put_byte(idx, 1'b0, ack);
      chk({15'h0, ack}, 16'h1);
      m.put_byte(d1, 1'b1, ack);
      chk({15'h0, ack}, 16'h1);
      m.put_byte(d2, 1'b0, ack);
      chk({15'h0, ack}, 16'h1);
      m.stop();
      chk(16'(exp_q.size()), 16'h0);
      // foreign address: no ack, line left high
      m.start();
      m.put_byte({TCI_TARGET_ADDR ^ (7'h01 << (2 * r)), 1'b1}, 1'b0, ack);
      m.get_byte(b);
      chk({7'h0, ack, b}, 16'h00ff);
      m.stop();
      // read with no index
      m.start();
      m.put_byte({TCI_TARGET_ADDR, 1'b1}, 1'b0, ack);
      m.get_byte(b);
      m.stop();
      chk({7'h0, ack, b}, {8'h01, regs[idx + 8'h02]});
      chk({req.addr, 7'h00, sda_oe}, {idx + 8'h03, 8'h00});
      chk(16'(n_rd), 16'(r + 1));
    end
    end_sim();
  end
endmodule
